// [logic/cwtc_top.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module cwtc_top
  import cwtc_pkg::*;
#(
  parameter int FS_DIVIDE = FS_DIV // Clock cycles per 1/fs
) (
  input  wire logic        I_CLK_SYS,     // 100 MHz clock
  input  wire logic        I_SRST,        // Sync reset, high
  input  wire logic [7:0]  I_ADDR,        // Register byte address
  input  wire logic [31:0] I_WDATA,       // Write data
  input  wire logic        I_WR,          // Write strobe
  input  wire logic        I_RD,          // Read strobe
  output var  logic [31:0] O_RDATA,       // Read data, cycle after strobe
  input  wire logic        I_CEC_IN,      // Bus line level
  output var  logic        O_CEC_OUT,     // Bus drive value, always 0
  output var  logic        O_CEC_OE_N,    // Drive enable, low drives
  output var  logic        O_TX_DONE_IRQ, // Transmit completion pulse
  output var  logic        O_WAVE_ERR_IRQ // Waveform error pulse
);
  // ===================================================================
  // Register storage
  logic [31:0]    wave_reg;
  logic [31:0]    txbuf_reg;
  logic [31:0]    txcr_reg;
  logic           txen_reg;
  logic           trans_reg;
  logic           done_reg;
  logic           oe_n_reg;
  logic           cec_out_reg;
  logic [31:0]    rdata_reg;
  logic [15:0]    fs_cnt_reg;
  logic           fs_tick_reg;
  cwtc_tx_state_t state_reg;
  cwtc_tx_state_t state_next;
  logic [3:0]     idx_reg;
  logic [3:0]     idx_next;
  logic [7:0]     tcnt_reg;
  logic [7:0]     tcnt_next;
  logic           done_next;
  logic           wave_err;

  // ===================================================================
  // Address decode
  wire sel_wave  = (I_ADDR == OFS_WAVE);
  wire sel_txen  = (I_ADDR == OFS_TXEN);
  wire sel_txbuf = (I_ADDR == OFS_TXBUF);
  wire sel_txcr  = (I_ADDR == OFS_TXCR);
  wire wr_wave   = I_WR && sel_wave;
  wire wr_txen   = I_WR && sel_txen;
  wire wr_txbuf  = I_WR && sel_txbuf;
  wire wr_txcr   = I_WR && sel_txcr;
  wire start_req = wr_txen && I_WDATA[TXEN_BIT];
  wire stop_req  = wr_txen && !I_WDATA[TXEN_BIT];

  // Read view; enable bit is write-only so it reads as 0
  wire [31:0] txen_view = {30'h0, trans_reg, 1'b0};
  wire [31:0] rd_mux;
  assign rd_mux = sel_wave  ? wave_reg  :
                  sel_txen  ? txen_view :
                  sel_txbuf ? txbuf_reg :
                  sel_txcr  ? txcr_reg  : 32'h0000_0000;

  // ===================================================================
  // Field extraction
  wire [2:0] wav3  = wave_reg[WAV3_LSB +: 3];
  wire [2:0] wav2  = wave_reg[WAV2_LSB +: 3];
  wire [2:0] wav1  = wave_reg[WAV1_LSB +: 3];
  wire [2:0] wav0  = wave_reg[WAV0_LSB +: 3];
  wire       waven = wave_reg[WAVEN_BIT];
  wire [2:0] strs  = txcr_reg[STRS_LSB +: 3];
  wire [2:0] sprd  = txcr_reg[SPRD_LSB +: 3];
  wire [1:0] dtrs  = txcr_reg[DTRS_LSB +: 2]; // Upper code values are reserved
  wire [3:0] dprd  = txcr_reg[DPRD_LSB +: 4];
  wire [3:0] free  = txcr_reg[FREE_LSB +: 4];

  // ===================================================================
  // Bit selection: index 0 is start, 1..8 data MSB first, 9 EOM, 10 ack
  wire [3:0] data_pos = 4'h8 - idx_reg;
  wire       data_bit = txbuf_reg[data_pos[2:0]];
  wire       cur_bit  = (idx_reg == 4'h9) ? txbuf_reg[EOM_BIT] :
                        (idx_reg == TX_LAST_BIT) ? 1'b1 : data_bit;
  wire       is_start = (state_reg != TX_FREE) && (idx_reg == 4'h0);

  // Rise and period lengths in 1/fs units
  wire [7:0] data_rise = (cur_bit ? ONE_RISE_BASE : ZERO_RISE_BASE)
                         - {6'h00, dtrs};
  wire [7:0] start_rise = START_RISE_BASE - {5'h00, strs};
  wire [7:0] start_prd  = START_PRD_BASE - {5'h00, sprd};
  wire [7:0] data_prd   = DATA_PRD_BASE - {4'h0, dprd};
  wire [7:0] rise_len   = is_start ? start_rise : data_rise;
  wire [7:0] prd_len    = is_start ? start_prd : data_prd;
  wire [7:0] tcnt_inc   = tcnt_reg + 8'h01;

  // ===================================================================
  // fs tick generator; a parameter so simulation can run faster
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      fs_cnt_reg  <= 16'h0000;
      fs_tick_reg <= 1'b0;
    end else if (fs_cnt_reg == 16'(FS_DIVIDE - 1)) begin
      fs_cnt_reg  <= 16'h0000;
      fs_tick_reg <= 1'b1;
    end else begin
      fs_cnt_reg  <= fs_cnt_reg + 16'h0001;
      fs_tick_reg <= 1'b0;
    end
  end

  // ===================================================================
  // Configuration registers
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      wave_reg  <= WAVE_RST;
      txbuf_reg <= TXBUF_RST;
      txcr_reg  <= TXCR_RST;
    end else begin
      if (wr_wave)
        wave_reg <= I_WDATA & WAVE_MASK;
      if (wr_txbuf)
        txbuf_reg <= I_WDATA & TXBUF_MASK;
      if (wr_txcr)
        txcr_reg <= I_WDATA & TXCR_MASK;
    end
  end

  // Read data stands for exactly one cycle after the strobe
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST)
      rdata_reg <= 32'h0000_0000;
    else
      rdata_reg <= I_RD ? rd_mux : 32'h0000_0000;
  end

  // ===================================================================
  // Transmit sequencer next state
  // Line sensed low while waiting for free time restarts the wait,
  // so a frame from another device always defers this one.
  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    tcnt_next  = tcnt_reg;
    done_next  = 1'b0;
    case (state_reg)
      TX_IDLE: begin
        if (start_req) begin
          state_next = TX_FREE;
          idx_next   = 4'h0;
          tcnt_next  = 8'h00;
        end
      end
      TX_FREE: begin
        if (!I_CEC_IN) begin
          idx_next  = 4'h0;
          tcnt_next = 8'h00;
        end else if (fs_tick_reg) begin
          if (tcnt_inc >= data_prd) begin
            tcnt_next = 8'h00;
            if (idx_reg == free) begin
              state_next = TX_LOW;
              idx_next   = 4'h0;
            end else begin
              idx_next = idx_reg + 4'h1;
            end
          end else begin
            tcnt_next = tcnt_inc;
          end
        end
      end
      TX_LOW: begin
        if (fs_tick_reg) begin
          tcnt_next = tcnt_inc;
          if (tcnt_inc >= rise_len)
            state_next = TX_HIGH;
        end
      end
      TX_HIGH: begin
        if (fs_tick_reg) begin
          if (tcnt_inc >= prd_len) begin
            tcnt_next = 8'h00;
            if (idx_reg == TX_LAST_BIT) begin
              state_next = TX_IDLE;
              done_next  = 1'b1;
            end else begin
              state_next = TX_LOW;
              idx_next   = idx_reg + 4'h1;
            end
          end else begin
            tcnt_next = tcnt_inc;
          end
        end
      end
      default: begin
        state_next = TX_IDLE;
      end
    endcase
    // Software stop or an error interrupt aborts at once
    if (stop_req || wave_err) begin
      state_next = TX_IDLE;
      done_next  = 1'b0;
    end
  end

  wire start_go = (state_reg == TX_FREE) && (state_next == TX_LOW);

  // ===================================================================
  // Sequencer state
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      state_reg <= TX_IDLE;
      idx_reg   <= 4'h0;
      tcnt_reg  <= 8'h00;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      tcnt_reg  <= tcnt_next;
      done_reg  <= done_next;
    end
  end

  // Enable and active flags; a start write wins over the auto clear of txen_reg,
  // but the sequencer starts only from TX_IDLE, so a restart written in the completion cycle is not sent.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      txen_reg  <= 1'b0;
      trans_reg <= 1'b0;
    end else begin
      if (start_req)
        txen_reg <= 1'b1;
      else if (stop_req || done_next || wave_err)
        txen_reg <= 1'b0;
      // Written data never reaches trans_reg
      if (start_go)
        trans_reg <= 1'b1;
      else if (done_next || wave_err || stop_req)
        trans_reg <= 1'b0;
    end
  end

  // Open-drain drive, only pulls low
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SRST) begin
      oe_n_reg    <= 1'b1;
      cec_out_reg <= 1'b0;
    end else begin
      oe_n_reg    <= (state_next != TX_LOW);
      cec_out_reg <= 1'b0;
    end
  end

  // ===================================================================
  // Receive waveform checker
  cwtc_wave_chk u_wave_chk (
    .i_clk     (I_CLK_SYS),
    .i_srst    (I_SRST),
    .i_fs_tick (fs_tick_reg),
    .i_en      (waven),
    .i_line    (I_CEC_IN),
    .i_wav3    (wav3),
    .i_wav2    (wav2),
    .i_wav1    (wav1),
    .i_wav0    (wav0),
    .o_err     (wave_err)
  );

  // ===================================================================
  // Outputs
  assign O_RDATA        = rdata_reg;
  assign O_CEC_OUT      = cec_out_reg;
  assign O_CEC_OE_N     = oe_n_reg;
  assign O_TX_DONE_IRQ  = done_reg;
  assign O_WAVE_ERR_IRQ = wave_err;

  // ===================================================================
  // Checks
  trans_rise_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (start_go && !stop_req && !wave_err) |=> (trans_reg && !O_CEC_OE_N))
    else $error("active flag not set with start bit");

  done_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_TX_DONE_IRQ |-> (!trans_reg && state_reg == TX_IDLE))
    else $error("active flag still set after completion");

  err_clear_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (O_WAVE_ERR_IRQ && !start_req) |=> (!trans_reg && !txen_reg))
    else $error("flags not cleared by error interrupt");

  trans_ro_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (wr_txen && I_WDATA[TRANS_BIT] && !I_WDATA[TXEN_BIT]) |=> !trans_reg)
    else $error("write reached the active flag");

  tx_start_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (start_req && state_reg == TX_IDLE && !wave_err)
      |=> (txen_reg && state_reg == TX_FREE) ##1 O_CEC_OE_N)
    else $error("transmit did not start on enable write");

  buf_store_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    wr_txbuf |=> (txbuf_reg[8:0] == $past(I_WDATA[8:0]) && txbuf_reg[31:9] == 23'h0))
    else $error("transmit buffer not stored");

  rise_time_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_reg == TX_LOW && fs_tick_reg && tcnt_inc == rise_len && !stop_req && !wave_err)
      |=> (state_reg == TX_HIGH) ##1 O_CEC_OE_N)
    else $error("line not released at rise time");

  read_once_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !I_RD |=> (O_RDATA == 32'h0000_0000))
    else $error("read data outside its cycle");

  // A stop write must leave nothing half driven on the shared line
  abort_release_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    stop_req |=> (O_CEC_OE_N && !trans_reg && !txen_reg && state_reg == TX_IDLE))
    else $error("line not released on transmit stop");

  done_enable_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (done_next && !start_req) |=> (O_TX_DONE_IRQ && !txen_reg))
    else $error("enable not cleared by completion");

  done_pulse_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    O_TX_DONE_IRQ |=> !O_TX_DONE_IRQ)
    else $error("completion pulse longer than one cycle");

  // Each bit restarts its timer, otherwise the periods would drift
  period_end_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_reg == TX_HIGH && fs_tick_reg && tcnt_inc == prd_len
      && idx_reg != TX_LAST_BIT && !stop_req && !wave_err)
      |=> (state_reg == TX_LOW && tcnt_reg == 8'h00 && !O_CEC_OE_N))
    else $error("next bit not started at period end");

  // Open drain: the pin may pull low only inside a low phase
  drive_low_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    !O_CEC_OE_N |-> (state_reg == TX_LOW && trans_reg))
    else $error("line pulled low outside a low phase");

  active_hold_a: assert property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    (state_reg == TX_LOW || state_reg == TX_HIGH) |-> trans_reg)
    else $error("active flag low while sending");

  start_cov: cover property (@(posedge I_CLK_SYS) disable iff (I_SRST) start_go);
  done_cov: cover property (@(posedge I_CLK_SYS) disable iff (I_SRST) O_TX_DONE_IRQ);
  err_cov: cover property (@(posedge I_CLK_SYS) disable iff (I_SRST) O_WAVE_ERR_IRQ);
  stop_cov: cover property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    stop_req && state_reg == TX_HIGH);
  abort_cov: cover property (@(posedge I_CLK_SYS) disable iff (I_SRST)
    stop_req && state_reg == TX_LOW);
endmodule : cwtc_top
`default_nettype wire

// [logic/cwtc_pkg.sv]
// =====================================================================
// Notes on behaviour
// - Waveform check flags a rising edge later than 56/fs plus 0..7/fs and earlier than 115/fs.
// - A missing rising edge is not flagged by itself; a low of 115/fs or more counts as a start bit.
// - Rising edge between late-one and early-zero limits is an error.
// - Rising edge earlier than 13/fs minus 0..7/fs is an error.
// - The four limits apply only while waveform checking is enabled.
// - Transmission-active goes to 1 when the start bit starts driving.
// - Transmission-active returns to 0 on completion or any interrupt.
// - Software writes to transmission-active, bit 1, are ignored.
// - Writing 1 to transmit enable starts sending; writing 0 stops it.
// - Transmit enable clears itself on completion or error interrupt.
// - Transmit buffer bits 7..0 hold the data byte, bit 7 the MSB.
// - Transmit buffer bit 8 holds the end-of-message bit, read and write.
// - Start bit rises at 121/fs minus 0..7, period 147/fs minus 0..7.
// - Data bit rises at 20/fs for one, 49/fs for zero, minus 0..3.
// - Data bit period is 79/fs minus 0..15/fs.
package cwtc_pkg;
  // ===================================================================
  // Register offsets
  localparam logic [7:0] OFS_WAVE  = 8'h00;
  localparam logic [7:0] OFS_TXEN  = 8'h04;
  localparam logic [7:0] OFS_TXBUF = 8'h08;
  localparam logic [7:0] OFS_TXCR  = 8'h0c;
  // ===================================================================
  // Field positions
  localparam int WAV3_LSB = 20;
  localparam int WAV2_LSB = 16;
  localparam int WAV1_LSB = 12;
  localparam int WAV0_LSB = 8;
  localparam int WAVEN_BIT = 0;
  localparam int TXEN_BIT = 0;
  localparam int TRANS_BIT = 1;
  localparam int EOM_BIT = 8;
  localparam int STRS_LSB = 20;
  localparam int SPRD_LSB = 16;
  localparam int DTRS_LSB = 12;
  localparam int DPRD_LSB = 8;
  localparam int BRD_BIT = 4;
  localparam int FREE_LSB = 0;
  // ===================================================================
  // Writable masks and reset values
  localparam logic [31:0] WAVE_MASK  = 32'h0077_7701;
  localparam logic [31:0] TXBUF_MASK = 32'h0000_01ff;
  localparam logic [31:0] TXCR_MASK  = 32'h0077_7f1f;
  localparam logic [31:0] WAVE_RST   = 32'h0000_0000;
  localparam logic [31:0] TXBUF_RST  = 32'h0000_0000;
  localparam logic [31:0] TXCR_RST   = 32'h0000_0000;
  // ===================================================================
  // Times in units of 1/fs
  localparam logic [7:0] LATE_ZERO_BASE  = 8'h38; // 56
  localparam logic [7:0] EARLY_ZERO_BASE = 8'h2b; // 43
  localparam logic [7:0] LATE_ONE_BASE   = 8'h1a; // 26
  localparam logic [7:0] EARLY_ONE_BASE  = 8'h0d; // 13
  localparam logic [7:0] START_MIN       = 8'h73; // 115, shortest start low
  localparam logic [7:0] FRAME_GAP       = 8'hc8; // 200, idle ends a frame
  localparam logic [7:0] START_RISE_BASE = 8'h79; // 121
  localparam logic [7:0] START_PRD_BASE  = 8'h93; // 147
  localparam logic [7:0] ONE_RISE_BASE   = 8'h14; // 20
  localparam logic [7:0] ZERO_RISE_BASE  = 8'h31; // 49
  localparam logic [7:0] DATA_PRD_BASE   = 8'h4f; // 79
  localparam logic [3:0] TX_LAST_BIT     = 4'ha;  // start, 8 data, EOM, ack
  // ===================================================================
  // Sampling rate
  localparam int CLK_HZ = 100_000_000;
  localparam int FS_HZ  = 32768;
  localparam int FS_DIV = CLK_HZ / FS_HZ;
  // ===================================================================
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FREE = 2'b01,
    TX_LOW  = 2'b10,
    TX_HIGH = 2'b11
  } cwtc_tx_state_t;
endpackage : cwtc_pkg

// [logic/cwtc_wave_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module cwtc_wave_chk
  import cwtc_pkg::*;
(
  input  wire logic       i_clk,     // System clock
  input  wire logic       i_srst,    // Sync reset, high
  input  wire logic       i_fs_tick, // One pulse per 1/fs
  input  wire logic       i_en,      // Waveform check enable
  input  wire logic       i_line,    // Bus line level
  input  wire logic [2:0] i_wav3,    // Late-zero trim
  input  wire logic [2:0] i_wav2,    // Early-zero trim
  input  wire logic [2:0] i_wav1,    // Late-one trim
  input  wire logic [2:0] i_wav0,    // Early-one trim
  output var  logic       o_err      // Waveform error pulse
);
  // ===================================================================
  // Edge detection and limits
  logic       line_d_reg;
  logic [7:0] cnt_reg;
  logic       in_frame_reg;
  wire        fall       = line_d_reg & ~i_line;
  wire        rise       = ~line_d_reg & i_line;
  wire  [7:0] late_zero  = LATE_ZERO_BASE + {5'h00, i_wav3};
  wire  [7:0] early_zero = EARLY_ZERO_BASE - {5'h00, i_wav2};
  wire  [7:0] late_one   = LATE_ONE_BASE + {5'h00, i_wav1};
  wire  [7:0] early_one  = EARLY_ONE_BASE - {5'h00, i_wav0};
  // Start bits are long lows; the START_MIN upper bound on late_bad keeps them out
  wire early_bad = rise && (cnt_reg < early_one);
  wire mid_bad   = rise && (cnt_reg > late_one) && (cnt_reg < early_zero);
  wire late_bad  = rise && (cnt_reg > late_zero) && (cnt_reg < START_MIN);
  wire bad       = i_en && in_frame_reg && (early_bad || mid_bad || late_bad);

  // ===================================================================
  // Bit timer, restarted by each falling edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      line_d_reg <= 1'b1;
      cnt_reg    <= 8'h00;
    end else begin
      line_d_reg <= i_line;
      if (fall)
        cnt_reg <= 8'h00;
      else if (i_fs_tick && cnt_reg != 8'hff)
        cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // Frame tracking and error pulse
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      in_frame_reg <= 1'b0;
      o_err        <= 1'b0;
    end else begin
      o_err <= bad;
      if (rise && cnt_reg >= START_MIN)
        in_frame_reg <= 1'b1;
      else if (i_line && cnt_reg >= FRAME_GAP)
        in_frame_reg <= 1'b0;
    end
  end

  // ===================================================================
  // Checks
  early_one_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (rise && i_en && in_frame_reg && cnt_reg < early_one) |=> o_err)
    else $error("early edge not flagged");
  check_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_en |=> !o_err)
    else $error("error flagged while check disabled");
  timer_restart_a: assert property (@(posedge i_clk) disable iff (i_srst)
    fall |=> (cnt_reg == 8'h00))
    else $error("bit timer not restarted");
endmodule : cwtc_wave_chk
`default_nettype wire

// [tb/cwtc_bus_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// Another device on the shared line: one start bit, one data bit, then idle
module cwtc_bus_peer #(
  parameter int DIV = 4 // Clocks per 1/fs
) (
  input  wire logic       i_clk,      // Clock
  input  wire logic       i_go,       // Frame request
  input  wire logic [7:0] i_low,      // Data bit low time, 1/fs units
  output var  logic       o_pull_low, // Pulls line low
  output var  logic       o_busy      // Frame in progress
);
  // One bit: low phase, then released; the pull-up brings the line high
  task automatic bit_out(input int lo, input int prd);
    o_pull_low <= 1'b1;
    repeat (lo * DIV) @(posedge i_clk);
    o_pull_low <= 1'b0;
    repeat ((prd - lo) * DIV) @(posedge i_clk);
  endtask : bit_out
  initial begin
    o_pull_low = 1'b0;
    o_busy = 1'b0;
  end
  // Long idle tail so the receiver closes the frame before the next one
  always begin
    @(posedge i_clk);
    while (!i_go)
      @(posedge i_clk);
    o_busy <= 1'b1;
    bit_out(120, 147);
    bit_out(i_low, 79);
    repeat (250 * DIV) @(posedge i_clk);
    o_busy <= 1'b0;
  end
endmodule : cwtc_bus_peer
`default_nettype wire

// [tb/cec_wave_check_and_tx_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module cec_wave_check_and_tx_control_tb import cwtc_pkg::*;;
  localparam int DIV = 4; // Short fs period keeps the run brief
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic [7:0]  low = 8'h00;
  logic [31:0] rdata, q;
  logic [9:0]  bits;
  logic        cec_out, oe_n, done_irq, err_irq, pull_low, busy;
  int          error_cnt = 0, checks_done = 0, done_n = 0, err_n = 0;
  int          n, lo, hi, e, e0;
  logic [7:0]  ofs [5] = '{OFS_WAVE, OFS_TXEN, OFS_TXBUF, OFS_TXCR, 8'h10};
  logic [31:0] msk [5] = '{WAVE_MASK, 32'h0, TXBUF_MASK, TXCR_MASK, 32'h0};
  logic [31:0] wcfg [10] = '{32'h1, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0,
                             32'h701, 32'h7001, 32'h70001, 32'h700001};
  logic [7:0]  wlow [10] = '{8'h05, 8'h14, 8'h23, 8'h31, 8'h46, 8'h23,
                             8'h09, 8'h1f, 8'h26, 8'h3d};
  logic        wexp [10] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0,
                             1'h0, 1'h0, 1'h0};
  // Open-drain line: anyone pulling low wins, pull-up otherwise
  wire         cec_line = (oe_n | cec_out) & ~pull_low;

  always #5 clk = ~clk;
  // Interrupt pulse counters
  always @(posedge clk) begin
    if (done_irq === 1'b1) done_n++;
    if (err_irq === 1'b1) err_n++;
  end

  cwtc_top #(.FS_DIVIDE(DIV)) cwtc_top_i (
    .I_CLK_SYS(clk), .I_SRST(srst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_CEC_IN(cec_line),
    .O_CEC_OUT(cec_out), .O_CEC_OE_N(oe_n), .O_TX_DONE_IRQ(done_irq),
    .O_WAVE_ERR_IRQ(err_irq));
  cwtc_bus_peer #(.DIV(DIV)) cwtc_bus_peer_i (
    .i_clk(clk), .i_go(go), .i_low(low), .o_pull_low(pull_low), .o_busy(busy));

  // ==================================================================
  // Helpers
  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // A wait that ran out of cycles is a mismatch and ends the run
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      close_out();
    end
  endtask : bound
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // Counts cycles until the line shows the wanted level
  task automatic wait_line(input logic lvl, output int cnt);
    cnt = 0;
    while (cec_line !== lvl && cnt < 3000) begin
      @(posedge clk);
      #1 cnt++;
    end
    bound(cnt, 3000);
  endtask : wait_line

  // ==================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Reset values, then writable bits; the active flag ignores writes
    foreach (ofs[i]) begin
      rreg(ofs[i], q);
      chk(q, 32'h0);
      wreg(ofs[i], (i == 1) ? 32'h2 : 32'hffff_ffff);
      rreg(ofs[i], q);
      chk(q, msk[i]);
      wreg(ofs[i], 32'h0);
    end
    // Receive edge windows: default limits, disabled check, each trim
    foreach (wcfg[i]) begin
      wreg(OFS_WAVE, wcfg[i]);
      low <= wlow[i];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      e0 = err_n;
      n = 0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      bound(n, 4000);
      chk(err_n - e0, wexp[i]);
    end
    // Transmit a5 with EOM, shortest start rise, data rise and period
    wreg(OFS_WAVE, 32'h0);
    wreg(OFS_TXBUF, 32'h0000_01a5);
    wreg(OFS_TXCR, 32'h0070_3f00);
    e0 = done_n;
    wreg(OFS_TXEN, 32'h1);
    rreg(OFS_TXEN, q);
    chk(q, 32'h0);
    wait_line(1'b0, n);
    wait_line(1'b1, lo);
    e = (START_RISE_BASE - 7) * DIV;
    chk(32'(lo >= e - 8 && lo <= e + 8), 32'h1);
    rreg(OFS_TXEN, q);
    chk(q, 32'h2);
    for (int b = 0; b < 10; b++) begin
      wait_line(1'b0, hi);
      e = (DATA_PRD_BASE - 15) * DIV;
      if (b == 2) chk(32'(lo + hi >= e - 8 && lo + hi <= e + 8), 32'h1);
      wait_line(1'b1, lo);
      bits = {bits[8:0], lo < 35 * DIV};
    end
    chk(bits, {8'ha5, 2'b11});
    e = (ONE_RISE_BASE - 3) * DIV;
    chk(32'(lo >= e - 8 && lo <= e + 8), 32'h1);
    n = 0;
    while (done_n == e0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    bound(n, 1000);
    rreg(OFS_TXEN, q);
    chk(q, 32'h0);
    // Abort during the start bit low phase: line released at once, no completion pulse
    e0 = done_n;
    wreg(OFS_TXEN, 32'h1);
    wait_line(1'b0, n);
    wreg(OFS_TXEN, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(32'(cec_line), 32'h1);
    chk(32'(cec_out), 32'h0);
    rreg(OFS_TXEN, q);
    chk(q, 32'h0);
    repeat (1000) @(posedge clk);
    chk(done_n - e0, 32'h0);
    close_out();
  end
endmodule : cec_wave_check_and_tx_control_tb
`default_nettype wire
